// ==== verilog/port_pin_value_cfg.svh ====
/*
 * Offsets, bit masks, reset values and bus widths for the six-pin port block.
 * Assumes byte addresses on the register bus, one 32-bit word per register.
 */
`ifndef PORT_PIN_VALUE_CFG_SVH
`define PORT_PIN_VALUE_CFG_SVH

`define PORT_PIN_VALUE_PINS 6
`define PORT_PIN_VALUE_ADDR_W 8
`define PORT_PIN_VALUE_DATA_W 32
`define PORT_PIN_VALUE_BE_W 4

`define PORT_PIN_VALUE_OFS_VALUE 8'h00
`define PORT_PIN_VALUE_OFS_LATCH 8'h04
`define PORT_PIN_VALUE_OFS_DIR 8'h08
`define PORT_PIN_VALUE_OFS_ANALOG 8'h0C
`define PORT_PIN_VALUE_OFS_OPENDRAIN 8'h10
`define PORT_PIN_VALUE_OFS_SLEW 8'h14
`define PORT_PIN_VALUE_OFS_THRESH 8'h18
`define PORT_PIN_VALUE_OFS_SOURCE 8'h1C

`define PORT_PIN_VALUE_ALL_PINS 6'h3F
`define PORT_PIN_VALUE_NO_PIN3 6'h37
`define PORT_PIN_VALUE_ANALOG_IMPL 6'h17
`define PORT_PIN_VALUE_PIN3_ONLY 6'h08
`define PORT_PIN_VALUE_NO_PINS 6'h00

`define PORT_PIN_VALUE_RST_LATCH 6'h00
`define PORT_PIN_VALUE_RST_DIR 6'h3F
`define PORT_PIN_VALUE_RST_ANALOG 6'h17
`define PORT_PIN_VALUE_RST_OPENDRAIN 6'h00
`define PORT_PIN_VALUE_RST_SLEW 6'h37
`define PORT_PIN_VALUE_RST_THRESH 6'h3F
`define PORT_PIN_VALUE_RST_SOURCE 6'h00

`define PORT_PIN_VALUE_DATA_LSB 0
`define PORT_PIN_VALUE_MASK_LSB 8
`define PORT_PIN_VALUE_DATA_LANE 0
`define PORT_PIN_VALUE_MASK_LANE 1
`define PORT_PIN_VALUE_READ_ZERO 32'h0000_0000

`endif

// ==== verilog/port_pin_value_pkg.sv ====
/*
 * Types shared by the six-pin port block and its input path.
 * Assumes port_pin_value_cfg.svh is on the include path.
 */
`include "port_pin_value_cfg.svh"

package port_pin_value_pkg;

    typedef logic [`PORT_PIN_VALUE_PINS-1:0] pin_vec_t;

    typedef enum {
        SEL_VALUE,
        SEL_LATCH,
        SEL_DIR,
        SEL_ANALOG,
        SEL_OPENDRAIN,
        SEL_SLEW,
        SEL_THRESH,
        SEL_SOURCE,
        SEL_NONE
    } reg_sel_t;

endpackage : port_pin_value_pkg

// ==== verilog/pin_input_sync.sv ====
/*
 * Input path of the port: synchronises both threshold comparators of each
 * pin, picks one per pin and blanks pins in analog mode.
 * Assumes pad comparator outputs are asynchronous to clk.
 */
`timescale 1ns/100ps
`include "port_pin_value_cfg.svh"

module pin_input_sync (
    input wire logic clk,
    input wire logic rst,
    input wire port_pin_value_pkg::pin_vec_t padInSchmitt,
    input wire port_pin_value_pkg::pin_vec_t padInTtl,
    input wire port_pin_value_pkg::pin_vec_t thresholdSel,
    input wire port_pin_value_pkg::pin_vec_t analogSel,
    output port_pin_value_pkg::pin_vec_t pinValue
);
    import port_pin_value_pkg::*;

    pin_vec_t schmittMeta;
    pin_vec_t schmittSync;
    pin_vec_t ttlMeta;
    pin_vec_t ttlSync;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            schmittMeta <= `PORT_PIN_VALUE_NO_PINS;
            schmittSync <= `PORT_PIN_VALUE_NO_PINS;
            ttlMeta <= `PORT_PIN_VALUE_NO_PINS;
            ttlSync <= `PORT_PIN_VALUE_NO_PINS;
        end else begin
            schmittMeta <= padInSchmitt;
            schmittSync <= schmittMeta;
            ttlMeta <= padInTtl;
            ttlSync <= ttlMeta;
        end
    end

    // threshold choice feeds both reads and change detection downstream
    always_ff @(posedge clk) begin
        if (rst) begin
            pinValue <= `PORT_PIN_VALUE_NO_PINS;
        end else begin
            pinValue <= ((thresholdSel & schmittSync) | (~thresholdSel & ttlSync))
                & ~analogSel;
        end
    end

endmodule : pin_input_sync

// ==== verilog/six_bit_port_a_io.sv ====
/*
 * Six-pin general purpose port: direction, latch, analog select, open-drain,
 * slew and threshold registers behind an Avalon-MM slave, plus pad drive.
 * Assumes a pad cell that resolves padOut/padOe and offers both comparators.
 */
// Implementation choices: the placing of the registers and register access over Avalon-MM.
// How it works
// - six pins, five of them two-way, each with direction, latch and input path
// - direction 1 turns the driver off; 0 drives the latch value
// - pin three is input only: direction reads 1, never driven
// - value register reads pins; writing it loads the latch
// - latch register writes and value register writes store identically
// - latch register reads return stored latch bits, not pins
// - writes merge untargeted bits from current pin levels into the latch
// - analog select turns off the digital input buffer
// - analog pins read zero in the value register
// - direction bit still governs the driver on analog pins
// - analog select never changes what the driver outputs
// - analog selects reset to analog; software clears before digital use
// - per-pin open-drain: set sinks only, clear drives both levels
// - per-pin slew bit: set limits slew, clear gives full rate
// - per-pin threshold picks Schmitt or TTL for reads and change detect
// - a pin given to a peripheral is not a port output but stays readable
// - after reset every pin takes its output source from its port latch, with all drivers off
`timescale 1ns/100ps
`include "port_pin_value_cfg.svh"

module six_bit_port_a_io (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`PORT_PIN_VALUE_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [`PORT_PIN_VALUE_DATA_W-1:0] writedata,
    input wire logic [`PORT_PIN_VALUE_BE_W-1:0] byteenable,
    output logic [`PORT_PIN_VALUE_DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire port_pin_value_pkg::pin_vec_t padInSchmitt,
    input wire port_pin_value_pkg::pin_vec_t padInTtl,
    output port_pin_value_pkg::pin_vec_t padOut,
    output port_pin_value_pkg::pin_vec_t padOe,
    output port_pin_value_pkg::pin_vec_t padSlewLimited,
    output port_pin_value_pkg::pin_vec_t analogSwitchOn,
    output port_pin_value_pkg::pin_vec_t digitalIn,
    input wire port_pin_value_pkg::pin_vec_t periphOut
);
    import port_pin_value_pkg::*;

    pin_vec_t outputLatch;
    pin_vec_t direction;
    pin_vec_t analogSel;
    pin_vec_t openDrain;
    pin_vec_t slewLimit;
    pin_vec_t thresholdSel;
    pin_vec_t periphSel;
    pin_vec_t pinValue;
    pin_vec_t outSource;
    pin_vec_t driveOn;
    pin_vec_t next_latch;
    pin_vec_t rmwTarget;
    logic ack;
    logic wrAccept;
    reg_sel_t sel;
    logic [`PORT_PIN_VALUE_DATA_W-1:0] readMux;

    function automatic reg_sel_t decode(input logic [`PORT_PIN_VALUE_ADDR_W-1:0] a);
        reg_sel_t s;
        unique case (a)
            `PORT_PIN_VALUE_OFS_VALUE: s = SEL_VALUE;
            `PORT_PIN_VALUE_OFS_LATCH: s = SEL_LATCH;
            `PORT_PIN_VALUE_OFS_DIR: s = SEL_DIR;
            `PORT_PIN_VALUE_OFS_ANALOG: s = SEL_ANALOG;
            `PORT_PIN_VALUE_OFS_OPENDRAIN: s = SEL_OPENDRAIN;
            `PORT_PIN_VALUE_OFS_SLEW: s = SEL_SLEW;
            `PORT_PIN_VALUE_OFS_THRESH: s = SEL_THRESH;
            `PORT_PIN_VALUE_OFS_SOURCE: s = SEL_SOURCE;
            default: s = SEL_NONE;
        endcase
        return s;
    endfunction : decode

    // only implemented bits move; the rest keep their constant
    function automatic pin_vec_t writeField(
        input pin_vec_t old,
        input pin_vec_t impl
    );
        pin_vec_t d;
        d = writedata[`PORT_PIN_VALUE_DATA_LSB +: `PORT_PIN_VALUE_PINS];
        return byteenable[`PORT_PIN_VALUE_DATA_LANE] ? ((old & ~impl) | (d & impl)) : old;
    endfunction : writeField

    function automatic logic [`PORT_PIN_VALUE_DATA_W-1:0] widen(input pin_vec_t v);
        return {{(`PORT_PIN_VALUE_DATA_W - `PORT_PIN_VALUE_PINS){1'b0}}, v};
    endfunction : widen

    assign sel = decode(address);

    // one wait state on every access, so read data can come from a flop
    always_ff @(posedge clk) begin
        if (rst) begin
            ack <= 1'b0;
        end else begin
            ack <= (read | write) & ~ack;
        end
    end

    assign waitrequest = (read | write) & ~ack;
    assign wrAccept = write & ack;

    always_comb begin
        unique case (sel)
            SEL_VALUE: readMux = widen(pinValue);
            SEL_LATCH: readMux = widen(outputLatch & `PORT_PIN_VALUE_NO_PIN3);
            SEL_DIR: readMux = widen(direction | `PORT_PIN_VALUE_PIN3_ONLY);
            SEL_ANALOG: readMux = widen(analogSel & `PORT_PIN_VALUE_ANALOG_IMPL);
            SEL_OPENDRAIN: readMux = widen(openDrain & `PORT_PIN_VALUE_NO_PIN3);
            SEL_SLEW: readMux = widen(slewLimit & `PORT_PIN_VALUE_NO_PIN3);
            SEL_THRESH: readMux = widen(thresholdSel);
            SEL_SOURCE: readMux = widen(periphSel & `PORT_PIN_VALUE_NO_PIN3);
            SEL_NONE: readMux = `PORT_PIN_VALUE_READ_ZERO;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            readdata <= `PORT_PIN_VALUE_READ_ZERO;
        end else if (read & ~ack) begin
            readdata <= readMux;
        end
    end

    // the merge uses pins as they read now, which is why analog pins
    // with drivers on can lose their latch value on a partial write
    always_comb begin
        rmwTarget = byteenable[`PORT_PIN_VALUE_MASK_LANE]
            ? writedata[`PORT_PIN_VALUE_MASK_LSB +: `PORT_PIN_VALUE_PINS] : `PORT_PIN_VALUE_ALL_PINS;
        next_latch = (pinValue & ~rmwTarget)
            | (writedata[`PORT_PIN_VALUE_DATA_LSB +: `PORT_PIN_VALUE_PINS] & rmwTarget);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            outputLatch <= `PORT_PIN_VALUE_RST_LATCH;
        end else if (wrAccept && byteenable[`PORT_PIN_VALUE_DATA_LANE]
                     && (sel == SEL_VALUE || sel == SEL_LATCH)) begin
            outputLatch <= next_latch & `PORT_PIN_VALUE_NO_PIN3;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            direction <= `PORT_PIN_VALUE_RST_DIR;
        end else if (wrAccept && sel == SEL_DIR) begin
            direction <= writeField(direction, `PORT_PIN_VALUE_NO_PIN3) | `PORT_PIN_VALUE_PIN3_ONLY;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            analogSel <= `PORT_PIN_VALUE_RST_ANALOG;
        end else if (wrAccept && sel == SEL_ANALOG) begin
            analogSel <= writeField(analogSel, `PORT_PIN_VALUE_ANALOG_IMPL) & `PORT_PIN_VALUE_ANALOG_IMPL;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            openDrain <= `PORT_PIN_VALUE_RST_OPENDRAIN;
        end else if (wrAccept && sel == SEL_OPENDRAIN) begin
            openDrain <= writeField(openDrain, `PORT_PIN_VALUE_NO_PIN3) & `PORT_PIN_VALUE_NO_PIN3;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            slewLimit <= `PORT_PIN_VALUE_RST_SLEW;
        end else if (wrAccept && sel == SEL_SLEW) begin
            slewLimit <= writeField(slewLimit, `PORT_PIN_VALUE_NO_PIN3) & `PORT_PIN_VALUE_NO_PIN3;
        end
    end

    // a threshold change can glitch the input path; software is expected
    // to have peripherals quiet while doing it
    always_ff @(posedge clk) begin
        if (rst) begin
            thresholdSel <= `PORT_PIN_VALUE_RST_THRESH;
        end else if (wrAccept && sel == SEL_THRESH) begin
            thresholdSel <= writeField(thresholdSel, `PORT_PIN_VALUE_ALL_PINS);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            periphSel <= `PORT_PIN_VALUE_RST_SOURCE;
        end else if (wrAccept && sel == SEL_SOURCE) begin
            periphSel <= writeField(periphSel, `PORT_PIN_VALUE_NO_PIN3) & `PORT_PIN_VALUE_NO_PIN3;
        end
    end

    pin_input_sync u_input (
        .clk(clk),
        .rst(rst),
        .padInSchmitt(padInSchmitt),
        .padInTtl(padInTtl),
        .thresholdSel(thresholdSel),
        .analogSel(analogSel),
        .pinValue(pinValue)
    );

    // analog select stays out of the output path entirely
    assign outSource = (periphSel & periphOut) | (~periphSel & outputLatch);
    assign driveOn = ~direction & `PORT_PIN_VALUE_NO_PIN3;
    assign padOe = driveOn & ~(openDrain & outSource);
    assign padOut = outSource & ~openDrain;
    assign padSlewLimited = slewLimit & `PORT_PIN_VALUE_NO_PIN3;
    assign analogSwitchOn = analogSel;
    assign digitalIn = pinValue;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_dirDrive;
        (padOe & direction) == `PORT_PIN_VALUE_NO_PINS
            && ((driveOn & ~openDrain) == (padOe & ~openDrain));
    endproperty
    a_dirDrive: assert property (p_dirDrive)
        else $error("driver enable disagrees with direction");

    property p_pin3Input;
        (padOe[3] == 1'b0) and ((read && !waitrequest && $past(sel) == SEL_DIR
            && $past(read)) |-> readdata[3]);
    endproperty
    a_pin3Input: assert property (p_pin3Input)
        else $error("input-only pin driven or direction bit clear");

    property p_valueWrite;
        (write && !waitrequest && sel inside {SEL_VALUE, SEL_LATCH}
            && byteenable[`PORT_PIN_VALUE_DATA_LANE])
            |=> outputLatch == ($past(next_latch) & `PORT_PIN_VALUE_NO_PIN3);
    endproperty
    a_valueWrite: assert property (p_valueWrite)
        else $error("latch did not take the merged write");

    property p_latchRead;
        (read && waitrequest && sel == SEL_LATCH)
            |=> readdata == widen($past(outputLatch) & `PORT_PIN_VALUE_NO_PIN3);
    endproperty
    a_latchRead: assert property (p_latchRead)
        else $error("latch read did not return latch contents");

    property p_analogReadsZero;
        (read && waitrequest && sel == SEL_VALUE)
            |=> (readdata[`PORT_PIN_VALUE_PINS-1:0] & $past(analogSel)) == `PORT_PIN_VALUE_NO_PINS;
    endproperty
    a_analogReadsZero: assert property (p_analogReadsZero)
        else $error("analog pin read as one");

    property p_analogNoOutput;
        (padOut == (outSource & ~openDrain))
            and ((periphSel == `PORT_PIN_VALUE_NO_PINS) |-> padOut == (outputLatch & ~openDrain));
    endproperty
    a_analogNoOutput: assert property (p_analogNoOutput)
        else $error("pad output not from latch source");

    // with no peripheral selected, an open-drain output pin pulls low exactly when its latch holds zero
    property p_openDrain;
        ((padOe & padOut & openDrain) == `PORT_PIN_VALUE_NO_PINS)
            and ((periphSel == `PORT_PIN_VALUE_NO_PINS) |-> (padOe & openDrain)
                == (~direction & openDrain & ~outputLatch & `PORT_PIN_VALUE_NO_PIN3));
    endproperty
    a_openDrain: assert property (p_openDrain)
        else $error("open-drain pin drove high");

    property p_resetDefaults;
        $past(rst) |-> analogSel == `PORT_PIN_VALUE_RST_ANALOG && periphSel == `PORT_PIN_VALUE_RST_SOURCE;
    endproperty
    a_resetDefaults: assert property (p_resetDefaults)
        else $error("analog select or source wrong after reset");

    property p_writeOnAccept;
        !(write && !waitrequest && sel == SEL_DIR) |=> $stable(direction);
    endproperty
    a_writeOnAccept: assert property (p_writeOnAccept)
        else $error("direction changed without accepted write");

    property p_slewFollows;
        (padSlewLimited == (slewLimit & `PORT_PIN_VALUE_NO_PIN3))
            && (padSlewLimited[3] == 1'b0);
    endproperty
    a_slewFollows: assert property (p_slewFollows)
        else $error("slew select does not follow its register");

endmodule : six_bit_port_a_io

// ==== bench/pin_partner.sv ====
/*
 * Board-side model of the six port pins: pull-ups, an external driver and
 * a per-pin mid-band level that splits the two input comparators.
 * Assumes the bench drives extLevel, extDrive and midBand.
 */
`timescale 1ns/100ps

module pin_partner (
    input wire port_pin_value_pkg::pin_vec_t padOut,
    input wire port_pin_value_pkg::pin_vec_t padOe,
    input wire port_pin_value_pkg::pin_vec_t extLevel,
    input wire port_pin_value_pkg::pin_vec_t extDrive,
    input wire port_pin_value_pkg::pin_vec_t midBand,
    output port_pin_value_pkg::pin_vec_t padInSchmitt,
    output port_pin_value_pkg::pin_vec_t padInTtl
);
    import port_pin_value_pkg::*;
    pin_vec_t wireLevel;
    // released pins with no external driver float high through board pull-ups, never keep a stale level
    assign wireLevel = (padOe & padOut) | (~padOe & extDrive & extLevel) | (~padOe & ~extDrive);
    // a level between the thresholds reads differently on each comparator
    assign padInTtl = wireLevel ^ midBand;
    assign padInSchmitt = wireLevel;
endmodule : pin_partner

// ==== bench/tb_six_bit_port_a_io.sv ====
/*
 * Self-checking bench for the six-pin port: register access over Avalon-MM,
 * pad drive, read-modify-write, analog blanking, threshold and source select.
 * Assumes port_pin_value_cfg.svh on the include path and pin_partner on the pads.
 */
`timescale 1ns/100ps
`include "port_pin_value_cfg.svh"

module tb_six_bit_port_a_io;
    import port_pin_value_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'h0;
    logic [31:0] readdata;
    logic waitrequest;
    pin_vec_t padInSchmitt, padInTtl, padOut, padOe, padSlewLimited, analogSwitchOn, digitalIn;
    pin_vec_t periphOut = 6'h00;
    pin_vec_t extLevel = 6'h00;
    pin_vec_t extDrive = 6'h00;
    pin_vec_t midBand = 6'h00;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;

    always #2.5 clk = ~clk;

    six_bit_port_a_io u_six_bit_port_a_io (.clk(clk), .rst(rst), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .padInSchmitt(padInSchmitt),
        .padInTtl(padInTtl), .padOut(padOut), .padOe(padOe), .padSlewLimited(padSlewLimited),
        .analogSwitchOn(analogSwitchOn), .digitalIn(digitalIn), .periphOut(periphOut));

    pin_partner u_pin_partner (.padOut(padOut), .padOe(padOe), .extLevel(extLevel),
        .extDrive(extDrive), .midBand(midBand), .padInSchmitt(padInSchmitt),
        .padInTtl(padInTtl));

    task automatic results;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    task automatic checkWord(input string name, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask : checkWord

    task automatic checkPins(input string name, input pin_vec_t e, input pin_vec_t g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask : checkPins

    // requests start one edge after the previous release, so no signal moves twice
    task automatic busWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        logic w;
        @(posedge clk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= 1'b1;
        do begin
            @(negedge clk);
            w = waitrequest;
            @(posedge clk);
        end while (w !== 1'b0);
        write <= 1'b0;
    endtask : busWrite

    task automatic readCheck(input logic [7:0] a, input logic [31:0] e, input string name);
        logic w;
        logic [31:0] d;
        int n = 0;
        @(posedge clk);
        address <= a;
        read <= 1'b1;
        do begin
            @(negedge clk);
            w = waitrequest;
            d = readdata;
            n += (w === 1'b1);
            @(posedge clk);
        end while (w !== 1'b0);
        read <= 1'b0;
        checkWord(name, e, d);
        checkWord("wait states", 32'h1, n);
    endtask : readCheck

    // pad input reaches reads after three edges of synchronisation
    task automatic settle;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic tReset;
        logic [7:0] ofs [7] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
        logic [31:0] expv [7] = '{32'h00, 32'h3F, 32'h17, 32'h00, 32'h37, 32'h3F, 32'h00};
        for (int i = 0; i < 7; i++) begin
            readCheck(ofs[i], expv[i], "reset value");
        end
        @(negedge clk);
        checkPins("padOe", 6'h00, padOe);
        checkPins("padSlewLimited", 6'h37, padSlewLimited);
        checkPins("analogSwitchOn", 6'h17, analogSwitchOn);
    endtask : tReset

    task automatic tDrive;
        busWrite(`PORT_PIN_VALUE_OFS_ANALOG, 32'h0, 4'h1);
        busWrite(`PORT_PIN_VALUE_OFS_LATCH, 32'h15, 4'h1);
        busWrite(`PORT_PIN_VALUE_OFS_DIR, 32'h0, 4'h1);
        readCheck(`PORT_PIN_VALUE_OFS_DIR, 32'h08, "direction");
        @(negedge clk);
        checkPins("padOe", 6'h37, padOe);
        checkPins("padOut", 6'h15, padOut & 6'h37);
        settle();
        readCheck(`PORT_PIN_VALUE_OFS_VALUE, 32'h1D, "pin value");
    endtask : tDrive

    task automatic tRmw;
        busWrite(`PORT_PIN_VALUE_OFS_VALUE, 32'h0202, 4'h3);
        readCheck(`PORT_PIN_VALUE_OFS_LATCH, 32'h17, "latch after value write");
        settle();
        busWrite(`PORT_PIN_VALUE_OFS_LATCH, 32'h1000, 4'h3);
        readCheck(`PORT_PIN_VALUE_OFS_LATCH, 32'h07, "latch after latch write");
        settle();
        readCheck(`PORT_PIN_VALUE_OFS_VALUE, 32'h0F, "pin value");
    endtask : tRmw

    task automatic tAnalog;
        busWrite(`PORT_PIN_VALUE_OFS_ANALOG, 32'h3F, 4'h1);
        readCheck(`PORT_PIN_VALUE_OFS_ANALOG, 32'h17, "analog select");
        @(negedge clk);
        checkPins("padOe", 6'h37, padOe);
        checkPins("padOut", 6'h07, padOut & 6'h37);
        checkPins("analogSwitchOn", 6'h17, analogSwitchOn);
        settle();
        checkPins("digitalIn", 6'h08, digitalIn);
        readCheck(`PORT_PIN_VALUE_OFS_VALUE, 32'h08, "analog read");
        busWrite(`PORT_PIN_VALUE_OFS_DIR, 32'h3F, 4'h1);
        extDrive <= 6'h3F;
        readCheck(`PORT_PIN_VALUE_OFS_LATCH, 32'h07, "latch with pins low");
        busWrite(`PORT_PIN_VALUE_OFS_ANALOG, 32'h0, 4'h1);
        settle();
        readCheck(`PORT_PIN_VALUE_OFS_VALUE, 32'h00, "pin value");
        extDrive <= 6'h00;
    endtask : tAnalog

    task automatic tDriver;
        busWrite(`PORT_PIN_VALUE_OFS_LATCH, 32'h05, 4'h1);
        busWrite(`PORT_PIN_VALUE_OFS_DIR, 32'h0, 4'h1);
        busWrite(`PORT_PIN_VALUE_OFS_OPENDRAIN, 32'h3F, 4'h1);
        readCheck(`PORT_PIN_VALUE_OFS_OPENDRAIN, 32'h37, "open drain");
        @(negedge clk);
        checkPins("padOe", 6'h32, padOe);
        checkPins("padOut", 6'h00, padOut & padOe);
        busWrite(`PORT_PIN_VALUE_OFS_OPENDRAIN, 32'h0, 4'h1);
        busWrite(`PORT_PIN_VALUE_OFS_SLEW, 32'h0, 4'h1);
        @(negedge clk);
        checkPins("padOe", 6'h37, padOe);
        checkPins("padSlewLimited", 6'h00, padSlewLimited);
        busWrite(`PORT_PIN_VALUE_OFS_SLEW, 32'h3F, 4'h1);
        @(negedge clk);
        checkPins("padSlewLimited", 6'h37, padSlewLimited);
    endtask : tDriver

    task automatic tPeriph;
        busWrite(`PORT_PIN_VALUE_OFS_LATCH, 32'h0, 4'h1);
        busWrite(`PORT_PIN_VALUE_OFS_SOURCE, 32'h01, 4'h1);
        periphOut <= 6'h3F;
        readCheck(`PORT_PIN_VALUE_OFS_SOURCE, 32'h01, "source select");
        @(negedge clk);
        checkPins("padOut", 6'h01, padOut & 6'h37);
        settle();
        readCheck(`PORT_PIN_VALUE_OFS_VALUE, 32'h09, "peripheral pin read");
        busWrite(`PORT_PIN_VALUE_OFS_SOURCE, 32'h0, 4'h1);
        busWrite(`PORT_PIN_VALUE_OFS_DIR, 32'h3F, 4'h1);
    endtask : tPeriph

    task automatic tThresh;
        extDrive <= 6'h3F;
        extLevel <= 6'h15;
        midBand <= 6'h3F;
        settle();
        readCheck(`PORT_PIN_VALUE_OFS_VALUE, 32'h15, "schmitt read");
        busWrite(`PORT_PIN_VALUE_OFS_THRESH, 32'h0F, 4'h1);
        settle();
        readCheck(`PORT_PIN_VALUE_OFS_VALUE, 32'h25, "mixed threshold read");
        @(negedge clk);
        checkPins("digitalIn", 6'h25, digitalIn);
        @(posedge clk);
        extLevel <= 6'h00;
        @(posedge clk);
        @(negedge clk);
        checkPins("digitalIn", 6'h25, digitalIn);
        settle();
        readCheck(`PORT_PIN_VALUE_OFS_VALUE, 32'h30, "ttl read");
        extDrive <= 6'h00;
    endtask : tThresh

    task automatic tUnmapped;
        busWrite(8'h20, 32'hFFFF_FFFF, 4'hF);
        readCheck(8'h20, 32'h0, "unmapped");
        busWrite(`PORT_PIN_VALUE_OFS_DIR, 32'hFFFF_FFC0, 4'hF);
        readCheck(`PORT_PIN_VALUE_OFS_DIR, 32'h08, "direction upper bits");
    endtask : tUnmapped

    always @(posedge clk) begin
        cycles <= cycles + 1;
        // the whole run takes well under a thousand cycles
        if (cycles == 5000) begin
            n_mismatch++;
            results();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        tReset();
        tDrive();
        tRmw();
        tAnalog();
        tDriver();
        tPeriph();
        tThresh();
        tUnmapped();
        results();
    end
endmodule : tb_six_bit_port_a_io
